// *** core/eld_pkg.sv ***
package eld_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  // Shortest half period: 20 Hz blink and 50 ms stretch.
  localparam int unsigned HALF_BASE_US = 25_000;
  localparam int unsigned HALF_BASE_CYC = HALF_BASE_US * CLK_MHZ;
  // Pulsing carrier: 5 kHz with a 20 percent on time.
  localparam int unsigned PWM_PERIOD_US = 200;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_US * CLK_MHZ;
  localparam int unsigned PWM_ON_PCT = 20;
  localparam int unsigned PWM_ON_CYC = PWM_PERIOD_CYC * PWM_ON_PCT / 100;
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned NUM_OUTS = 5;
  localparam logic [1:0] RATE_FASTEST = 2'h3;
  localparam logic [3:0] FC_LINK_ACT = 4'h0;
  localparam logic [3:0] FC_LINK1000 = 4'h1;
  localparam logic [3:0] FC_LINK100 = 4'h2;
  localparam logic [3:0] FC_LINK10 = 4'h3;
  localparam logic [3:0] FC_LINK100_1000 = 4'h4;
  localparam logic [3:0] FC_LINK10_1000 = 4'h5;
  localparam logic [3:0] FC_LINK10_100 = 4'h6;
  localparam logic [3:0] FC_RSVD_A = 4'h7;
  localparam logic [3:0] FC_DUPLEX_COL = 4'h8;
  localparam logic [3:0] FC_COLLISION = 4'h9;
  localparam logic [3:0] FC_ACTIVITY = 4'hA;
  localparam logic [3:0] FC_RSVD_B = 4'hB;
  localparam logic [3:0] FC_PD_FAULT = 4'hC;
  localparam logic [3:0] FC_RSVD_C = 4'hD;
  localparam logic [3:0] FC_FORCE_OFF = 4'hE;
  localparam logic [3:0] FC_FORCE_ON = 4'hF;
  typedef enum logic [1:0] {
    ELD_SPD_10, ELD_SPD_100, ELD_SPD_1000, ELD_SPD_NONE
  } eld_speed_e;
endpackage

// *** core/eld_tb_if.sv ***
`timescale 1ns/1ns
interface eld_tb_if;
  logic base_tick;
  logic pwm_on;
  modport src (output base_tick, output pwm_on);
  modport snk (input base_tick, input pwm_on);
endinterface

// *** core/eld_timebase.sv ***
`timescale 1ns/1ns
module eld_timebase
  import eld_pkg::*;
#(
  parameter int unsigned HALF_CYC = eld_pkg::HALF_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  eld_tb_if.src tb
);
  localparam int unsigned CW = $clog2(HALF_CYC);
  localparam int unsigned PW = $clog2(PWM_PERIOD_CYC);
  typedef struct packed {
    logic [CW-1:0] half_cnt;
    logic [PW-1:0] pwm_cnt;
    logic tick;
    logic pwm_on;
  } eld_tbst_s;
  eld_tbst_s s_ff;
  eld_tbst_s nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.half_cnt == CW'(HALF_CYC - 1)) begin
      nxt_s.half_cnt = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.half_cnt = s_ff.half_cnt + 1'b1;
    end
    if (s_ff.pwm_cnt == PW'(PWM_PERIOD_CYC - 1)) begin
      nxt_s.pwm_cnt = '0;
    end else begin
      nxt_s.pwm_cnt = s_ff.pwm_cnt + 1'b1;
    end
    nxt_s.pwm_on = (nxt_s.pwm_cnt < PW'(PWM_ON_CYC));
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign tb.base_tick = s_ff.tick;
  assign tb.pwm_on = s_ff.pwm_on;
endmodule // eld_timebase

// *** core/eld_pin.sv ***
`timescale 1ns/1ns
module eld_pin
  import eld_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  eld_tb_if.snk tb,
  input wire logic evt,
  input wire logic stretch,
  input wire logic [1:0] rate,
  output logic show
);
  typedef enum logic [1:0] {
    ELD_IDLE, ELD_FIRST, ELD_SECOND, ELD_HOLD
  } eld_pst_e;
  typedef struct packed {
    eld_pst_e st;
    logic [3:0] cnt;
    logic pend;
  } eld_pin_s;
  eld_pin_s s_ff;
  eld_pin_s nxt_s;
  logic [3:0] last;
  logic half_done;

  // Half period is 1, 2, 4 or 8 base ticks.
  assign last = (4'h1 << (RATE_FASTEST - rate)) - 4'h1;
  assign half_done = tb.base_tick && (s_ff.cnt >= last);

  always_comb begin
    nxt_s = s_ff;
    if (tb.base_tick) begin
      nxt_s.cnt = s_ff.cnt + 4'h1;
    end
    if (evt) begin
      nxt_s.pend = 1'b1;
    end
    case (s_ff.st)
      ELD_IDLE: begin
        nxt_s.cnt = '0;
        nxt_s.pend = 1'b0;
        if (evt) begin
          nxt_s.st = ELD_FIRST;
        end
      end
      ELD_FIRST: begin
        if (half_done) begin
          nxt_s.cnt = '0;
          if (stretch) begin
            nxt_s.st = ELD_SECOND;
            nxt_s.pend = evt;
          end else begin
            nxt_s.st = ELD_HOLD;
          end
        end
      end
      ELD_SECOND: begin
        if (half_done) begin
          nxt_s.cnt = '0;
          nxt_s.pend = evt;
          nxt_s.st = (s_ff.pend || evt) ? ELD_SECOND : ELD_HOLD;
        end
      end
      ELD_HOLD: begin
        if (half_done) begin
          nxt_s.cnt = '0;
          nxt_s.pend = 1'b0;
          nxt_s.st = (s_ff.pend || evt) ? ELD_FIRST : ELD_IDLE;
        end
      end
      default: begin
        nxt_s.st = ELD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign show = (s_ff.st == ELD_FIRST) || (s_ff.st == ELD_SECOND);
endmodule // eld_pin

// *** core/eld_top.sv ***
// Operation
// - Enhanced mode runs when the mode select is zero; codes chosen per pin.
// - Enhanced mode drives outputs one to four; output five stays disabled.
// - Power-down forces every indicator to its off state.
// - Code 0: off without link, on with link, activity turns it off.
// - Codes 1-3: as code 0 for 1000, 100 and 10 links only.
// - Codes 4-6: as code 0 for 100/1000, 10/1000, 10/100 links.
// - Code 8: on for full duplex, collisions on half duplex light it.
// - Code 9: off normally, collision events light it.
// - Code 10: activity lights it; only transmit counts when selected.
// - Code 12: on while the parallel-detect fault input is high.
// - Code 14 forces off, code 15 forces on.
// - Per-pin combine disable shows only the primary status on codes 0-6 and 8.
// - Per-pin enable picks pulse-stretch instead of blink.
// - Blink is 50 percent duty; one event lasts half a period.
// - Stretch holds one period per event, off states last half period.
// - Per-pin blink rate 2.5, 5, 10 or 20 Hz.
// - Per-pin stretch period 50, 100, 200 or 400 ms, same field.
// - Pulsing modulates asserted outputs at 5 kHz, 20 percent on.
// - Per-pin polarity, default taken from the strap level.
`timescale 1ns/1ns
module eld_top
  import eld_pkg::*;
#(
  parameter int unsigned HALF_CYC = eld_pkg::HALF_BASE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic indicator_mode_sel,
  input wire logic power_down,
  input wire logic link_up,
  input wire eld_pkg::eld_speed_e link_speed,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic rx_act,
  input wire logic tx_act,
  input wire logic act_tx_only,
  input wire logic pd_fault,
  input wire logic [3:0][3:0] func_code,
  input wire logic [3:0] combine_dis,
  input wire logic [3:0] stretch_en,
  input wire logic [3:0][1:0] rate_sel,
  input wire logic pulsing_en,
  input wire logic [4:0] pol_strap,
  input wire logic pol_wr,
  input wire logic [4:0] pol_wr_val,
  output logic [4:0] pol_now,
  output logic indicator_out_one,
  output logic indicator_out_two,
  output logic indicator_out_three,
  output logic indicator_out_four,
  output logic indicator_out_five,
  output logic indicator_oe_one_b,
  output logic indicator_oe_two_b,
  output logic indicator_oe_three_b,
  output logic indicator_oe_four_b,
  output logic indicator_oe_five_b
);
  import eld_pkg::*;

  if (HALF_CYC < 2) begin : g_bad_half
    $error("HALF_CYC must be at least 2");
  end

  typedef struct packed {
    logic strap_done;
    logic [4:0] pol;
    logic [4:0] out;
    logic [4:0] oe_b;
  } eld_top_s;

  eld_top_s s_ff;
  eld_top_s nxt_s;
  eld_tb_if tb_bus ();

  logic act_any;
  logic lk10;
  logic lk100;
  logic lk1000;
  logic [3:0] prim;
  logic [3:0] sec;
  logic [3:0] sec_on;
  logic [3:0] combo;
  logic [3:0] eng_evt;
  logic [3:0] show;
  logic [3:0] use_show;
  logic [3:0] asserted;
  logic [3:0] lit;
  logic enh;

  eld_timebase #(
    .HALF_CYC(HALF_CYC)
  ) u_timebase (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .ce(ce),
    .tb(tb_bus)
  );

  assign enh = ~indicator_mode_sel;
  assign act_any = tx_act | (rx_act & ~act_tx_only);
  assign lk10 = link_up && (link_speed == ELD_SPD_10);
  assign lk100 = link_up && (link_speed == ELD_SPD_100);
  assign lk1000 = link_up && (link_speed == ELD_SPD_1000);

  // Primary level, secondary event, and whether the event lights it.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      prim[i] = 1'b0;
      sec[i] = 1'b0;
      sec_on[i] = 1'b0;
      combo[i] = 1'b0;
      case (func_code[i])
        FC_LINK_ACT: begin
          prim[i] = link_up;
          sec[i] = link_up & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK1000: begin
          prim[i] = lk1000;
          sec[i] = lk1000 & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK100: begin
          prim[i] = lk100;
          sec[i] = lk100 & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK10: begin
          prim[i] = lk10;
          sec[i] = lk10 & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK100_1000: begin
          prim[i] = lk100 | lk1000;
          sec[i] = (lk100 | lk1000) & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK10_1000: begin
          prim[i] = lk10 | lk1000;
          sec[i] = (lk10 | lk1000) & act_any;
          combo[i] = 1'b1;
        end
        FC_LINK10_100: begin
          prim[i] = lk10 | lk100;
          sec[i] = (lk10 | lk100) & act_any;
          combo[i] = 1'b1;
        end
        FC_DUPLEX_COL: begin
          prim[i] = link_up & full_duplex;
          sec[i] = link_up & ~full_duplex & collision;
          sec_on[i] = 1'b1;
          combo[i] = 1'b1;
        end
        FC_COLLISION: begin
          sec[i] = collision;
          sec_on[i] = 1'b1;
        end
        FC_ACTIVITY: begin
          sec[i] = act_any;
          sec_on[i] = 1'b1;
        end
        FC_PD_FAULT: begin
          prim[i] = pd_fault;
        end
        FC_FORCE_OFF: begin
          prim[i] = 1'b0;
        end
        FC_FORCE_ON: begin
          prim[i] = 1'b1;
        end
        default: begin
          prim[i] = 1'b0;
        end
      endcase
    end
  end

  // Combine disable blocks the secondary indication on codes 0-6 and 8.
  assign eng_evt = sec & ~(combo & combine_dis);
  assign use_show = show & ~(combo & combine_dis) & (combo | sec_on);

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    eld_pin u_pin (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ce(ce),
      .tb(tb_bus),
      .evt(eng_evt[g]),
      .stretch(stretch_en[g]),
      .rate(rate_sel[g]),
      .show(show[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (sec_on[i]) begin
        asserted[i] = prim[i] | use_show[i];
      end else begin
        asserted[i] = prim[i] & ~use_show[i];
      end
    end
  end

  assign lit = asserted & {NUM_PINS{~pulsing_en | tb_bus.pwm_on}}
             & {NUM_PINS{~power_down}};

  always_comb begin
    nxt_s = s_ff;
    if (!s_ff.strap_done) begin
      nxt_s.pol = pol_strap;
      nxt_s.strap_done = 1'b1;
    end else if (pol_wr) begin
      nxt_s.pol = pol_wr_val;
    end
    // Off level is the inverse of the active level.
    nxt_s.out = ~nxt_s.pol;
    nxt_s.oe_b = '1;
    if (enh) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        nxt_s.out[i] = lit[i] ? nxt_s.pol[i] : ~nxt_s.pol[i];
        nxt_s.oe_b[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_ff <= '{strap_done: 1'b0, pol: '0, out: '0, oe_b: '1};
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign pol_now = s_ff.pol;
  assign indicator_out_one = s_ff.out[0];
  assign indicator_out_two = s_ff.out[1];
  assign indicator_out_three = s_ff.out[2];
  assign indicator_out_four = s_ff.out[3];
  assign indicator_out_five = s_ff.out[4];
  assign indicator_oe_one_b = s_ff.oe_b[0];
  assign indicator_oe_two_b = s_ff.oe_b[1];
  assign indicator_oe_three_b = s_ff.oe_b[2];
  assign indicator_oe_four_b = s_ff.oe_b[3];
  assign indicator_oe_five_b = s_ff.oe_b[4];

  // Quiet conditions under which an output's next value is predictable.
  logic norm;
  assign norm = ce & enh & ~power_down & ~pol_wr & s_ff.strap_done;

  a_pin_five_off:
  assert property (@(posedge clk_sys) disable iff (!rst_b)
    ce && enh && s_ff.strap_done
    |=> indicator_oe_five_b && (s_ff.out[4] == ~s_ff.pol[4]))
  else $error("output five driven in enhanced mode");

  a_strap_polarity:
  assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(s_ff.strap_done) |-> s_ff.pol == $past(pol_strap))
  else $error("polarity not taken from strap");

  for (genvar g = 0; g < NUM_PINS; g++) begin : g_chk
    a_enh_drives:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      ce && enh && s_ff.strap_done |=> !s_ff.oe_b[g])
    else $error("enhanced pin not driven");

    a_powerdown_off:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      ce && power_down && !pol_wr && s_ff.strap_done
      |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("pin not off in power-down");

    a_force_on:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && func_code[g] == FC_FORCE_ON
      |=> s_ff.out[g] == s_ff.pol[g])
    else $error("forced-on pin not asserted");

    a_force_off:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && func_code[g] == FC_FORCE_OFF
      |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("forced-off pin asserted");

    a_reserved_off:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && (func_code[g] == FC_RSVD_A || func_code[g] == FC_RSVD_B
      || func_code[g] == FC_RSVD_C) |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("reserved code asserted pin");

    a_fault_on:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && pd_fault && func_code[g] == FC_PD_FAULT
      |=> s_ff.out[g] == s_ff.pol[g])
    else $error("fault code not asserted");

    a_link_steady:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && link_up && !show[g]
      && func_code[g] == FC_LINK_ACT |=> s_ff.out[g] == s_ff.pol[g])
    else $error("linked pin not on");

    a_combine_off:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && combine_dis[g] && lk1000
      && func_code[g] == FC_LINK1000 |=> s_ff.out[g] == s_ff.pol[g])
    else $error("combine disable ignored");

    a_duplex_on:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && link_up && full_duplex
      && func_code[g] == FC_DUPLEX_COL |=> s_ff.out[g] == s_ff.pol[g])
    else $error("full duplex pin not on");

    a_collision_idle:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !show[g] && func_code[g] == FC_COLLISION
      |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("collision pin on without event");

    a_pulse_gap:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && pulsing_en && !tb_bus.pwm_on
      |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("pin lit during pulsing gap");

    a_mode_release:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      ce && !enh |=> s_ff.oe_b[g])
    else $error("pin driven outside enhanced mode");

    a_activity_on:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && !pulsing_en && use_show[g] && func_code[g] == FC_ACTIVITY
      |=> s_ff.out[g] == s_ff.pol[g])
    else $error("activity pin not lit");

    a_link_act_off:
    assert property (@(posedge clk_sys) disable iff (!rst_b)
      norm && link_up && use_show[g] && func_code[g] == FC_LINK_ACT
      |=> s_ff.out[g] == ~s_ff.pol[g])
    else $error("linked pin not dark during activity");
  end
endmodule // eld_top

// *** dv/eld_led_model.sv ***
`timescale 1ns/1ns
module eld_led_model (
  input wire logic pin,
  input wire logic oe_b,
  input wire logic active_high,
  output logic lit
);
  // The lamp glows only while the pin is driven at its asserted level.
  assign lit = !oe_b && (pin === active_high);
endmodule // eld_led_model

// *** dv/eld_top_tb.sv ***
`timescale 1ns/1ns
module eld_top_tb;
  import eld_pkg::*;
  localparam int HC = 4;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic mode_sel = 1'b0, pwr_dn = 1'b0, link_up = 1'b0, fdx = 1'b0;
  logic col = 1'b0, rx = 1'b0, tx = 1'b0, tx_only = 1'b0, pdf = 1'b0;
  logic pulse_en = 1'b0, pol_wr = 1'b0;
  logic [4:0] pol_wr_val = 5'h00;
  logic [4:0] pol_exp = 5'h15;
  logic [4:0] strap = 5'h15;
  logic [3:0][3:0] fc = '0;
  logic [3:0] comb_dis = 4'h0, stretch = 4'h0;
  eld_speed_e spd = ELD_SPD_NONE;
  wire logic [4:0] outs, oe_b, pol_now;
  wire logic [3:0] lit;
  int cnt [4];
  int bad_count = 0;
  int check_count = 0;
  int seed_junk;

  always #25 clk_sys = ~clk_sys;

  eld_top #(.HALF_CYC(HC)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1),
    .indicator_mode_sel(mode_sel), .power_down(pwr_dn),
    .link_up(link_up), .link_speed(spd), .full_duplex(fdx),
    .collision(col), .rx_act(rx), .tx_act(tx), .act_tx_only(tx_only),
    .pd_fault(pdf), .func_code(fc), .combine_dis(comb_dis),
    .stretch_en(stretch), .rate_sel(8'hE4), .pulsing_en(pulse_en),
    .pol_strap(strap), .pol_wr(pol_wr), .pol_wr_val(pol_wr_val),
    .pol_now(pol_now),
    .indicator_out_one(outs[0]), .indicator_out_two(outs[1]),
    .indicator_out_three(outs[2]), .indicator_out_four(outs[3]),
    .indicator_out_five(outs[4]),
    .indicator_oe_one_b(oe_b[0]), .indicator_oe_two_b(oe_b[1]),
    .indicator_oe_three_b(oe_b[2]), .indicator_oe_four_b(oe_b[3]),
    .indicator_oe_five_b(oe_b[4])
  );

  for (genvar g = 0; g < 4; g++) begin : g_led
    eld_led_model u_led (
      .pin(outs[g]), .oe_b(oe_b[g]), .active_high(pol_exp[g]), .lit(lit[g])
    );
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic tally(input int n);
    cnt = '{default: 0};
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      for (int g = 0; g < 4; g++) cnt[g] += int'(lit[g]);
      if ($isunknown(lit)) bad_count++;
    end
  endtask

  function automatic int hf(input int g);
    return HC << (3 - g);
  endfunction

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction

  function automatic logic exp_on(input logic [3:0] c, input logic lk,
                                  input eld_speed_e sp, input logic fd,
                                  input logic pf);
    logic s10, s100, s1g;
    s10 = lk && sp == ELD_SPD_10;
    s100 = lk && sp == ELD_SPD_100;
    s1g = lk && sp == ELD_SPD_1000;
    case (c)
      FC_LINK_ACT: return lk;
      FC_LINK1000: return s1g;
      FC_LINK100: return s100;
      FC_LINK10: return s10;
      FC_LINK100_1000: return s100 || s1g;
      FC_LINK10_1000: return s10 || s1g;
      FC_LINK10_100: return s10 || s100;
      FC_DUPLEX_COL: return lk && fd;
      FC_PD_FAULT: return pf;
      FC_FORCE_ON: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    #(50 * 100000);
    bad_count++;
    final_report();
  end

  initial begin
    seed_junk = $urandom(91591);
    strap <= 5'($urandom);
    tick(5);
    rst_b <= 1'b1;
    pol_exp <= strap;
    tick(3);
    check(32'(pol_now), 32'(strap));
    pol_wr <= 1'b1;
    pol_wr_val <= 5'h0B;
    @(posedge clk_sys);
    pol_wr <= 1'b0;
    pol_exp <= 5'h0B;
    tick(2);
    check(32'(pol_now), 32'h0B);
    $display("test polarity done");
    // Steady indications for every code, then random codes; status random throughout.
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      link_up <= 1'($urandom);
      spd <= eld_speed_e'($urandom_range(2));
      fdx <= 1'($urandom);
      pdf <= 1'($urandom);
      comb_dis <= 4'($urandom);
      for (int g = 0; g < 4; g++) begin
        fc[g] <= (i < 4) ? 4'(i * 4 + g) : 4'($urandom);
      end
      tally(4);
      for (int g = 0; g < 4; g++) begin
        check(32'(lit[g]), 32'(exp_on(fc[g], link_up, spd, fdx, pdf)));
      end
      check(32'({oe_b[4], outs[4]}), 32'({1'b1, ~pol_exp[4]}));
    end
    $display("test static codes done");
    // Single events with blink and with stretch on every rate.
    link_up <= 1'b1;
    fdx <= 1'b0;
    tx_only <= 1'b1;
    comb_dis <= 4'h0;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys);
        stretch <= s ? 4'hF : 4'h0;
        fc <= {4{(k == 0) ? FC_COLLISION : (k == 1) ? FC_DUPLEX_COL
                                                    : FC_ACTIVITY}};
        tick(100);
        if (k == 2) tx <= 1'b1;
        else col <= 1'b1;
        @(posedge clk_sys);
        tx <= 1'b0;
        col <= 1'b0;
        tally(300);
        for (int g = 0; g < 4; g++) begin
          check(inr(cnt[g], (s + 1) * hf(g) - HC, (s + 1) * hf(g)), 1);
        end
      end
    end
    $display("test single events done");
    // Continuous receive activity.
    @(posedge clk_sys);
    stretch <= 4'h0;
    rx <= 1'b1;
    tally(256);
    for (int g = 0; g < 4; g++) check(cnt[g], 0);
    @(posedge clk_sys);
    tx_only <= 1'b0;
    tick(80);
    tally(256);
    for (int g = 0; g < 4; g++) check(cnt[g], 128);
    @(posedge clk_sys);
    stretch <= 4'hF;
    tick(80);
    tally(256);
    for (int g = 0; g < 4; g++) check(cnt[g], 256);
    @(posedge clk_sys);
    rx <= 1'b0;
    tally(300);
    for (int g = 0; g < 4; g++) begin
      check(inr(cnt[g], hf(g) - HC, 3 * hf(g) + 2), 1);
    end
    $display("test continuous activity done");
    // Link with activity, combined and not combined.
    @(posedge clk_sys);
    fc <= {4{FC_LINK_ACT}};
    stretch <= 4'h0;
    comb_dis <= 4'hF;
    rx <= 1'b1;
    tick(80);
    tally(256);
    for (int g = 0; g < 4; g++) check(cnt[g], 256);
    @(posedge clk_sys);
    comb_dis <= 4'h0;
    tick(80);
    tally(256);
    for (int g = 0; g < 4; g++) check(cnt[g], 128);
    $display("test combine done");
    // Power saving modulation.
    @(posedge clk_sys);
    rx <= 1'b0;
    fc <= {FC_FORCE_ON, FC_FORCE_ON, FC_FORCE_OFF, FC_FORCE_OFF};
    pulse_en <= 1'b1;
    tick(50);
    tally(4000);
    for (int g = 0; g < 4; g++) check(cnt[g], (g > 1) ? 800 : 0);
    $display("test pulsing done");
    // Power-down and mode select.
    @(posedge clk_sys);
    pulse_en <= 1'b0;
    fc <= {4{FC_FORCE_ON}};
    pwr_dn <= 1'b1;
    tally(4);
    check(32'({oe_b, lit}), 32'h100);
    @(posedge clk_sys);
    pwr_dn <= 1'b0;
    mode_sel <= 1'b1;
    tally(4);
    check(32'(oe_b), 32'h1F);
    @(posedge clk_sys);
    mode_sel <= 1'b0;
    tally(4);
    check(32'({oe_b, lit}), 32'h10F);
    $display("test power and mode done");
    final_report();
  end
endmodule // eld_top_tb
